//--- dpc_pkg.sv
`default_nettype none
package dpc_pkg;
	// Bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int REG_W = 16;
	localparam int NUM_REGS = 18;
	localparam int SYNC_STAGES = 3;

	// Register indices, byte address is four times the index
	localparam logic [9:0] IDX_SWITCH_METHOD = 10'h07C;
	localparam logic [9:0] IDX_SWITCH_METHOD_M2 = 10'h07D;
	localparam logic [9:0] IDX_ACCEL_FREQ = 10'h07E;
	localparam logic [9:0] IDX_ACCEL_FREQ_M2 = 10'h07F;
	localparam logic [9:0] IDX_DECEL_FREQ = 10'h080;
	localparam logic [9:0] IDX_DECEL_FREQ_M2 = 10'h081;
	localparam logic [9:0] IDX_ACCEL_CURVE = 10'h082;
	localparam logic [9:0] IDX_DECEL_CURVE = 10'h083;
	localparam logic [9:0] IDX_CIN_START_FREQ = 10'h084;
	localparam logic [9:0] IDX_CIN_END_FREQ = 10'h085;
	localparam logic [9:0] IDX_CIN_START_PCT = 10'h086;
	localparam logic [9:0] IDX_CIN_END_PCT = 10'h087;
	localparam logic [9:0] IDX_CIN_START_OPT = 10'h088;
	localparam logic [9:0] IDX_OPERAND_A = 10'h0E3;
	localparam logic [9:0] IDX_OPERAND_B = 10'h0E4;
	localparam logic [9:0] IDX_OPERATION = 10'h0E5;
	localparam logic [9:0] IDX_OFFSET_FREQ = 10'h0E6;
	localparam logic [9:0] IDX_OFFSET_DIR = 10'h0E7;

	// Storage slots
	localparam logic [4:0] SLOT_SWITCH_METHOD = 5'h00;
	localparam logic [4:0] SLOT_SWITCH_METHOD_M2 = 5'h01;
	localparam logic [4:0] SLOT_ACCEL_FREQ = 5'h02;
	localparam logic [4:0] SLOT_ACCEL_FREQ_M2 = 5'h03;
	localparam logic [4:0] SLOT_DECEL_FREQ = 5'h04;
	localparam logic [4:0] SLOT_DECEL_FREQ_M2 = 5'h05;
	localparam logic [4:0] SLOT_ACCEL_CURVE = 5'h06;
	localparam logic [4:0] SLOT_DECEL_CURVE = 5'h07;
	localparam logic [4:0] SLOT_CIN_START_FREQ = 5'h08;
	localparam logic [4:0] SLOT_CIN_END_FREQ = 5'h09;
	localparam logic [4:0] SLOT_CIN_START_PCT = 5'h0A;
	localparam logic [4:0] SLOT_CIN_END_PCT = 5'h0B;
	localparam logic [4:0] SLOT_CIN_START_OPT = 5'h0C;
	localparam logic [4:0] SLOT_OPERAND_A = 5'h0D;
	localparam logic [4:0] SLOT_OPERAND_B = 5'h0E;
	localparam logic [4:0] SLOT_OPERATION = 5'h0F;
	localparam logic [4:0] SLOT_OFFSET_FREQ = 5'h10;
	localparam logic [4:0] SLOT_OFFSET_DIR = 5'h11;

	// Upper limits of the legal ranges
	localparam logic [15:0] MAX_FLAG = 16'h0001;
	localparam logic [15:0] MAX_FREQ = 16'h0FA0;
	localparam logic [15:0] MAX_PCT = 16'h0064;
	localparam logic [15:0] MAX_SOURCE = 16'h0004;
	localparam logic [15:0] MAX_OPERATION = 16'h0002;

	// Option codes
	localparam logic [15:0] CODE_ONE = 16'h0001;
	localparam logic [15:0] SRC_PANEL = 16'h0000;
	localparam logic [15:0] SRC_KEYPAD_POT = 16'h0001;
	localparam logic [15:0] SRC_VOLTAGE_IN = 16'h0002;
	localparam logic [15:0] SRC_CURRENT_IN = 16'h0003;
	localparam logic [15:0] OP_ADD = 16'h0000;
	localparam logic [15:0] OP_SUB = 16'h0001;

	// Reset values and bus answers
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : dpc_pkg
`default_nettype wire

//--- dpc_regs.sv
// Local design decision: the AXI4-Lite interface to the registers.
`default_nettype none
// Behaviour
// RL1: Per-motor profile switch method, codes 0-1
// RL2: Per-motor accel transition frequency, 0-4000
// RL3: Per-motor decel transition frequency, 0-4000
// RL4: Accel/decel curve select, linear or S
// RL5: Current-input start/end frequency, 0-4000
// RL6: Current-input start/end percent, 0-100
// RL7: Start option: stored start or zero
// RL8: Operand A source select, codes 0-4
// RL9: Operand B source select, codes 0-4
// RL10: Calculate: add, subtract or multiply
// RL11: Offset applied only while terminal on
// RL12: Direction picks add or subtract offset
// RL13: Unsigned counts; out-of-range writes rejected
module dpc_regs (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// AXI4-Lite write address
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Terminals
	input wire logic offset_enable_pin,
	input wire logic motor2_select_pin,
	// Calculate sources and frequency setting, same clock domain
	input wire logic [15:0] panel_setting,
	input wire logic [15:0] keypad_pot,
	input wire logic [15:0] voltage_input,
	input wire logic [15:0] current_input,
	input wire logic [15:0] network_variable,
	input wire logic [15:0] freq_setting,
	// Profile controls for the active motor
	output logic switch_method_q,
	output logic [15:0] accel_switch_freq_q,
	output logic [15:0] decel_switch_freq_q,
	output logic accel_s_curve_q,
	output logic decel_s_curve_q,
	// Current input scaling
	output logic [15:0] cin_start_freq_q,
	output logic [15:0] cin_end_freq_q,
	output logic [15:0] cin_start_pct_q,
	output logic [15:0] cin_end_pct_q,
	// Results
	output logic [31:0] calc_result_q,
	output logic [15:0] out_freq_q
);
	// Address to storage slot, bit 5 marks a hit
	function automatic logic [5:0] dpc_decode(input logic [11:0] addr);
		logic [9:0] idx;
		idx = addr[11:2];
		if (idx == dpc_pkg::IDX_SWITCH_METHOD) begin
			dpc_decode = {1'b1, dpc_pkg::SLOT_SWITCH_METHOD};
		end else if (idx == dpc_pkg::IDX_SWITCH_METHOD_M2) begin
			dpc_decode = {1'b1, dpc_pkg::SLOT_SWITCH_METHOD_M2};
		end else if (idx == dpc_pkg::IDX_ACCEL_FREQ) begin
			dpc_decode = {1'b1, dpc_pkg::SLOT_ACCEL_FREQ};
		end else if (idx == dpc_pkg::IDX_ACCEL_FREQ_M2) begin
			dpc_decode = {1'b1, dpc_pkg::SLOT_ACCEL_FREQ_M2};
		end else if (idx == dpc_pkg::IDX_DECEL_FREQ) begin
			dpc_decode = {1'b1, dpc_pkg::SLOT_DECEL_FREQ};
		end else if (idx == dpc_pkg::IDX_DECEL_FREQ_M2) begin
			dpc_decode = {1'b1, dpc_pkg::SLOT_DECEL_FREQ_M2};
		end else if (idx == dpc_pkg::IDX_ACCEL_CURVE) begin
			dpc_decode = {1'b1, dpc_pkg::SLOT_ACCEL_CURVE};
		end else if (idx == dpc_pkg::IDX_DECEL_CURVE) begin
			dpc_decode = {1'b1, dpc_pkg::SLOT_DECEL_CURVE};
		end else if (idx == dpc_pkg::IDX_CIN_START_FREQ) begin
			dpc_decode = {1'b1, dpc_pkg::SLOT_CIN_START_FREQ};
		end else if (idx == dpc_pkg::IDX_CIN_END_FREQ) begin
			dpc_decode = {1'b1, dpc_pkg::SLOT_CIN_END_FREQ};
		end else if (idx == dpc_pkg::IDX_CIN_START_PCT) begin
			dpc_decode = {1'b1, dpc_pkg::SLOT_CIN_START_PCT};
		end else if (idx == dpc_pkg::IDX_CIN_END_PCT) begin
			dpc_decode = {1'b1, dpc_pkg::SLOT_CIN_END_PCT};
		end else if (idx == dpc_pkg::IDX_CIN_START_OPT) begin
			dpc_decode = {1'b1, dpc_pkg::SLOT_CIN_START_OPT};
		end else if (idx == dpc_pkg::IDX_OPERAND_A) begin
			dpc_decode = {1'b1, dpc_pkg::SLOT_OPERAND_A};
		end else if (idx == dpc_pkg::IDX_OPERAND_B) begin
			dpc_decode = {1'b1, dpc_pkg::SLOT_OPERAND_B};
		end else if (idx == dpc_pkg::IDX_OPERATION) begin
			dpc_decode = {1'b1, dpc_pkg::SLOT_OPERATION};
		end else if (idx == dpc_pkg::IDX_OFFSET_FREQ) begin
			dpc_decode = {1'b1, dpc_pkg::SLOT_OFFSET_FREQ};
		end else if (idx == dpc_pkg::IDX_OFFSET_DIR) begin
			dpc_decode = {1'b1, dpc_pkg::SLOT_OFFSET_DIR};
		end else begin
			dpc_decode = 6'h00;
		end
	endfunction : dpc_decode

	// Largest legal count of each slot
	function automatic logic [15:0] dpc_limit(input logic [4:0] slot);
		case (slot)
			dpc_pkg::SLOT_ACCEL_FREQ, dpc_pkg::SLOT_ACCEL_FREQ_M2, dpc_pkg::SLOT_DECEL_FREQ,
			dpc_pkg::SLOT_DECEL_FREQ_M2, dpc_pkg::SLOT_CIN_START_FREQ,
			dpc_pkg::SLOT_CIN_END_FREQ, dpc_pkg::SLOT_OFFSET_FREQ: dpc_limit = dpc_pkg::MAX_FREQ;
			dpc_pkg::SLOT_CIN_START_PCT, dpc_pkg::SLOT_CIN_END_PCT: dpc_limit = dpc_pkg::MAX_PCT;
			dpc_pkg::SLOT_OPERAND_A, dpc_pkg::SLOT_OPERAND_B: dpc_limit = dpc_pkg::MAX_SOURCE;
			dpc_pkg::SLOT_OPERATION: dpc_limit = dpc_pkg::MAX_OPERATION;
			default: dpc_limit = dpc_pkg::MAX_FLAG;
		endcase
	endfunction : dpc_limit

	// Calculate source by code; codes above 4 cannot be stored
	function automatic logic [15:0] dpc_source(input logic [15:0] code, input logic [15:0] p,
		input logic [15:0] k, input logic [15:0] v, input logic [15:0] c, input logic [15:0] n);
		if (code == dpc_pkg::SRC_PANEL) begin
			dpc_source = p;
		end else if (code == dpc_pkg::SRC_KEYPAD_POT) begin
			dpc_source = k;
		end else if (code == dpc_pkg::SRC_VOLTAGE_IN) begin
			dpc_source = v;
		end else if (code == dpc_pkg::SRC_CURRENT_IN) begin
			dpc_source = c;
		end else begin
			dpc_source = n;
		end
	endfunction : dpc_source

	logic [15:0] regs_q [0:17];
	logic aw_held_q, w_held_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [11:0] awaddr_q;
	logic [31:0] wdata_q, rdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;
	logic [2:0] sync_q [0:1];
	logic offset_on_q, motor2_q;

	// Bus handshakes and next-state terms
	wire aw_hs = s_axi_awvalid & awready_q;
	wire w_hs = s_axi_wvalid & wready_q;
	wire ar_hs = s_axi_arvalid & arready_q;
	wire wr_commit = aw_held_q & w_held_q & ~bvalid_q;
	wire bvalid_d = wr_commit | (bvalid_q & ~s_axi_bready);
	wire aw_held_d = (aw_held_q & ~wr_commit) | aw_hs;
	wire w_held_d = (w_held_q & ~wr_commit) | w_hs;
	wire rvalid_d = ar_hs | (rvalid_q & ~s_axi_rready);

	// Write decode, byte merge and range check
	wire [5:0] wr_dec = dpc_decode(awaddr_q);
	wire wr_hit = wr_dec[5];
	wire [4:0] wr_slot = wr_dec[4:0];
	wire [15:0] wr_old = regs_q[wr_slot];
	wire [15:0] wr_new = {wstrb_q[1] ? wdata_q[15:8] : wr_old[15:8],
		wstrb_q[0] ? wdata_q[7:0] : wr_old[7:0]};
	wire wr_ok = wr_hit & (wr_new <= dpc_limit(wr_slot)); // RL13
	wire [1:0] wr_resp = ~wr_hit ? dpc_pkg::RESP_DECERR
		: (wr_ok ? dpc_pkg::RESP_OKAY : dpc_pkg::RESP_SLVERR);

	// Read decode
	wire [5:0] rd_dec = dpc_decode(s_axi_araddr);
	wire [31:0] rd_data = rd_dec[5] ? {16'h0000, regs_q[rd_dec[4:0]]} : 32'h0000_0000;
	wire [1:0] rd_resp = rd_dec[5] ? dpc_pkg::RESP_OKAY : dpc_pkg::RESP_DECERR;

	// Bus ports straight from flops
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// Write channel: hold address and data until both are in
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= dpc_pkg::RESP_OKAY;
		end else begin
			aw_held_q <= aw_held_d;
			w_held_q <= w_held_d;
			awready_q <= ~aw_held_d & ~bvalid_d;
			wready_q <= ~w_held_d & ~bvalid_d;
			bvalid_q <= bvalid_d;
			if (wr_commit) begin
				bresp_q <= wr_resp;
			end
		end
	end

	// Payload capture, no reset needed
	always_ff @(posedge clk_sys) begin
		if (aw_hs) begin
			awaddr_q <= s_axi_awaddr;
		end
		if (w_hs) begin
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end
	end

	// Read channel: one read in flight, answered the cycle after
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= dpc_pkg::RESP_OKAY;
		end else begin
			arready_q <= ~rvalid_d;
			rvalid_q <= rvalid_d;
			if (ar_hs) begin
				rdata_q <= rd_data;
				rresp_q <= rd_resp;
			end
		end
	end

	// Register storage; a rejected write leaves the old count
	genvar gi;
	generate
		for (gi = 0; gi < dpc_pkg::NUM_REGS; gi++) begin : g_reg
			always_ff @(posedge clk_sys) begin
				if (rst) begin
					regs_q[gi] <= dpc_pkg::REG_RESET;
				end else if (wr_commit && wr_ok && wr_slot == 5'(gi)) begin
					regs_q[gi] <= wr_new; // RL13
				end
			end
		end
	endgenerate

	// Terminal synchronisers; a change counts once stages two and three agree
	wire [1:0] pin_in = {motor2_select_pin, offset_enable_pin};
	generate
		for (gi = 0; gi < 2; gi++) begin : g_sync
			always_ff @(posedge clk_sys) begin
				if (rst) begin
					sync_q[gi] <= 3'h0;
				end else begin
					sync_q[gi] <= {sync_q[gi][1:0], pin_in[gi]};
				end
			end
		end
	endgenerate

	wire offset_stable = sync_q[0][1] == sync_q[0][2];
	wire motor2_stable = sync_q[1][1] == sync_q[1][2];

	// Filtered terminal levels
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			offset_on_q <= 1'b0;
			motor2_q <= 1'b0;
		end else begin
			if (offset_stable) begin
				offset_on_q <= sync_q[0][2];
			end
			if (motor2_stable) begin
				motor2_q <= sync_q[1][2];
			end
		end
	end

	// Per-motor profile selection
	wire [15:0] method_sel = motor2_q ? regs_q[dpc_pkg::SLOT_SWITCH_METHOD_M2]
		: regs_q[dpc_pkg::SLOT_SWITCH_METHOD];
	wire [15:0] acc_sel = motor2_q ? regs_q[dpc_pkg::SLOT_ACCEL_FREQ_M2]
		: regs_q[dpc_pkg::SLOT_ACCEL_FREQ];
	wire [15:0] dec_sel = motor2_q ? regs_q[dpc_pkg::SLOT_DECEL_FREQ_M2]
		: regs_q[dpc_pkg::SLOT_DECEL_FREQ];

	// Calculate operands and offset terms
	wire [15:0] opa_val = dpc_source(regs_q[dpc_pkg::SLOT_OPERAND_A], panel_setting,
		keypad_pot, voltage_input, current_input, network_variable); // RL8
	wire [15:0] opb_val = dpc_source(regs_q[dpc_pkg::SLOT_OPERAND_B], panel_setting,
		keypad_pot, voltage_input, current_input, network_variable); // RL9
	wire [15:0] calc_op = regs_q[dpc_pkg::SLOT_OPERATION];
	wire [15:0] ofs = regs_q[dpc_pkg::SLOT_OFFSET_FREQ];
	wire ofs_minus = regs_q[dpc_pkg::SLOT_OFFSET_DIR] == dpc_pkg::CODE_ONE;
	wire [16:0] ofs_sum = {1'b0, freq_setting} + {1'b0, ofs};
	// Minus floors at zero so the drive never sees a wrapped frequency
	wire [15:0] ofs_diff = (freq_setting > ofs) ? freq_setting - ofs : 16'h0000;
	wire [15:0] ofs_plus = ofs_sum[16] ? 16'hFFFF : ofs_sum[15:0];

	// Profile and curve outputs
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			switch_method_q <= 1'b0;
			accel_switch_freq_q <= dpc_pkg::REG_RESET;
			decel_switch_freq_q <= dpc_pkg::REG_RESET;
			accel_s_curve_q <= 1'b0;
			decel_s_curve_q <= 1'b0;
		end else begin
			switch_method_q <= method_sel == dpc_pkg::CODE_ONE; // RL1
			accel_switch_freq_q <= acc_sel; // RL2
			decel_switch_freq_q <= dec_sel; // RL3
			accel_s_curve_q <= regs_q[dpc_pkg::SLOT_ACCEL_CURVE] == dpc_pkg::CODE_ONE; // RL4
			decel_s_curve_q <= regs_q[dpc_pkg::SLOT_DECEL_CURVE] == dpc_pkg::CODE_ONE; // RL4
		end
	end

	// Current input scaling outputs
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cin_start_freq_q <= dpc_pkg::REG_RESET;
			cin_end_freq_q <= dpc_pkg::REG_RESET;
			cin_start_pct_q <= dpc_pkg::REG_RESET;
			cin_end_pct_q <= dpc_pkg::REG_RESET;
		end else begin
			cin_start_freq_q <= (regs_q[dpc_pkg::SLOT_CIN_START_OPT] == dpc_pkg::CODE_ONE)
				? 16'h0000 : regs_q[dpc_pkg::SLOT_CIN_START_FREQ]; // RL7
			cin_end_freq_q <= regs_q[dpc_pkg::SLOT_CIN_END_FREQ]; // RL5
			cin_start_pct_q <= regs_q[dpc_pkg::SLOT_CIN_START_PCT]; // RL6
			cin_end_pct_q <= regs_q[dpc_pkg::SLOT_CIN_END_PCT]; // RL6
		end
	end

	// Calculate function and offset frequency
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			calc_result_q <= 32'h0000_0000;
			out_freq_q <= dpc_pkg::REG_RESET;
		end else begin
			if (calc_op == dpc_pkg::OP_ADD) begin
				calc_result_q <= {16'h0000, opa_val} + {16'h0000, opb_val}; // RL10
			end else if (calc_op == dpc_pkg::OP_SUB) begin
				calc_result_q <= {16'h0000, opa_val} - {16'h0000, opb_val}; // RL10
			end else begin
				calc_result_q <= {16'h0000, opa_val} * {16'h0000, opb_val}; // RL10
			end
			if (!offset_on_q) begin
				out_freq_q <= freq_setting; // RL11
			end else begin
				out_freq_q <= ofs_minus ? ofs_diff : ofs_plus; // RL12
			end
		end
	end

	default clocking dpc_cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	chk_reject_range: assert property ( // RL13
		wr_commit && wr_hit && !wr_ok |=> s_axi_bvalid && s_axi_bresp == dpc_pkg::RESP_SLVERR
			&& regs_q[$past(wr_slot)] == $past(wr_old))
		else $error("out-of-range write changed a register");
	chk_method_legal: assert property ( // RL1
		regs_q[dpc_pkg::SLOT_SWITCH_METHOD] <= 16'h0001
			&& regs_q[dpc_pkg::SLOT_SWITCH_METHOD_M2] <= 16'h0001)
		else $error("switch method out of range");
	chk_accel_motor: assert property ( // RL2
		motor2_q && $stable(motor2_q) |=> accel_switch_freq_q == $past(regs_q[3])
			&& accel_switch_freq_q <= 16'h0FA0)
		else $error("accel transition not from second motor");
	chk_decel_motor: assert property ( // RL3
		!motor2_q ##1 !motor2_q |=> decel_switch_freq_q == $past(regs_q[4]))
		else $error("decel transition not from first motor");
	chk_curve_shape: assert property ( // RL4
		regs_q[dpc_pkg::SLOT_DECEL_CURVE] == 16'h0000 |=> !decel_s_curve_q)
		else $error("linear decel code gave S-curve");
	chk_cin_freqs: assert property ( // RL5
		regs_q[dpc_pkg::SLOT_CIN_END_FREQ] <= 16'h0FA0 |=> cin_end_freq_q <= 16'h0FA0)
		else $error("current input frequency out of range");
	chk_cin_pct: assert property ( // RL6
		cin_start_pct_q <= 16'h0064 && cin_end_pct_q <= 16'h0064)
		else $error("current input percent above 100");
	chk_zero_start: assert property ( // RL7
		regs_q[dpc_pkg::SLOT_CIN_START_OPT] == 16'h0001 |=> cin_start_freq_q == 16'h0000)
		else $error("zero start option ignored");
	chk_operand_sel: assert property ( // RL8
		regs_q[dpc_pkg::SLOT_OPERAND_A] == 16'h0003 |-> opa_val == current_input)
		else $error("operand A not current input");
	chk_operand_b: assert property ( // RL9
		regs_q[dpc_pkg::SLOT_OPERAND_B] <= 16'h0004)
		else $error("operand B select out of range");
	chk_calc_sub: assert property ( // RL10
		calc_op == 16'h0001 |=> calc_result_q == 32'($past(opa_val) - $past(opb_val)))
		else $error("subtract result wrong");
	chk_offset_gate: assert property ( // RL11
		!offset_on_q |=> out_freq_q == $past(freq_setting))
		else $error("offset applied while terminal off");
	chk_offset_plus: assert property ( // RL12
		offset_on_q && !ofs_minus && !ofs_sum[16] |=> out_freq_q == $past(ofs_sum[15:0]))
		else $error("plus offset not added");

	cov_write_ok: cover property (wr_commit && wr_ok);
	cov_write_reject: cover property (wr_commit && wr_hit && !wr_ok);
	cov_read: cover property (ar_hs ##1 s_axi_rvalid);
	cov_multiply: cover property (calc_op == dpc_pkg::MAX_OPERATION && offset_on_q);
endmodule : dpc_regs
`default_nettype wire

//--- dpc_axi_master.sv
`default_nettype none
// Network master model: one write and one read at a time
module dpc_axi_master (
	// Clock
	input wire logic clk_sys,
	// Write request
	output logic [11:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	// Write answer
	input wire logic bvalid,
	output logic bready,
	// Read request and answer
	output logic [11:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	output logic rready
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle bus at time zero
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end

	// Payload inverted once taken, so a stale value is never mistaken for a live one
	task automatic write(input logic [11:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= {16'h0000, d};
		wstrb <= 4'h3;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (awvalid && awready) begin
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				wdata <= ~wdata;
			end
		end while (!bvalid);
		bready <= 1'b0;
	endtask : write

	// Read held until the answer is sampled
	task automatic read(input logic [11:0] a);
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (arvalid && arready) begin
				arvalid <= 1'b0;
				araddr <= ~a;
			end
		end while (!rvalid);
		rready <= 1'b0;
	endtask : read
endmodule : dpc_axi_master
`default_nettype wire

//--- tb_drive_profile_calc_regs.sv
`default_nettype none
module tb_drive_profile_calc_regs;
	timeunit 1ns;
	timeprecision 1ps;
	// Bus, pins, sources and outputs
	logic clk_sys, rst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, off_en, m2_sel, sw_m, acc_s, dec_s;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, calc;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [15:0] src[5];
	logic [15:0] fset, acc_f, dec_f, cs_f, ce_f, cs_p, ce_p, ofreq;
	logic [1:0] wq[$];
	logic [33:0] rq[$];
	int n_errors, compares, seed;

	// Free-running 40 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	dpc_regs i_dut (.clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .offset_enable_pin(off_en), .motor2_select_pin(m2_sel),
		.panel_setting(src[0]), .keypad_pot(src[1]), .voltage_input(src[2]),
		.current_input(src[3]), .network_variable(src[4]), .freq_setting(fset),
		.switch_method_q(sw_m), .accel_switch_freq_q(acc_f), .decel_switch_freq_q(dec_f),
		.accel_s_curve_q(acc_s), .decel_s_curve_q(dec_s), .cin_start_freq_q(cs_f),
		.cin_end_freq_q(ce_f), .cin_start_pct_q(cs_p), .cin_end_pct_q(ce_p),
		.calc_result_q(calc), .out_freq_q(ofreq));

	dpc_axi_master i_mst (.clk_sys(clk_sys), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rvalid(rvalid), .rready(rready));

	// One comparison, counted
	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic stop_test;
		$display("compares %0d, n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test

	// Answers compared in order against the oldest note
	always @(posedge clk_sys) begin
		if (bvalid && bready)
			check(34'(bresp), 34'(wq.pop_front()));
		if (rvalid && rready)
			check({rresp, rdata}, rq.pop_front());
	end

	task automatic wr(input logic [9:0] i, input logic [15:0] d, input logic [1:0] e);
		wq.push_back(e);
		i_mst.write({i, 2'b00}, d);
	endtask : wr

	task automatic rd(input logic [9:0] i, input logic [1:0] e, input logic [15:0] d);
		rq.push_back({e, 16'h0000, d});
		i_mst.read({i, 2'b00});
	endtask : rd

	// Register index of table entry k
	function automatic logic [9:0] idx(input int k);
		idx = (k < 13) ? 10'(10'h07C + k) : 10'(10'h0E3 + k - 13);
	endfunction : idx

	// Top of each register's legal range
	function automatic logic [15:0] lim(input logic [9:0] i);
		case (i)
			10'h07E, 10'h07F, 10'h080, 10'h081, 10'h084, 10'h085, 10'h0E6: lim = dpc_pkg::MAX_FREQ;
			10'h086, 10'h087: lim = dpc_pkg::MAX_PCT;
			10'h0E3, 10'h0E4: lim = dpc_pkg::MAX_SOURCE;
			10'h0E5: lim = dpc_pkg::MAX_OPERATION;
			default: lim = dpc_pkg::MAX_FLAG;
		endcase
	endfunction : lim

	function automatic logic [31:0] cexp(input logic [15:0] a, input logic [15:0] b, input int op);
		case (op)
			0: cexp = {16'h0000, a} + {16'h0000, b};
			1: cexp = {16'h0000, a} - {16'h0000, b};
			default: cexp = {16'h0000, a} * {16'h0000, b};
		endcase
	endfunction : cexp

	// Main sequence
	initial begin
		logic [15:0] v;
		logic [15:0] e;
		seed = 32'h08b9;
		n_errors = 0;
		compares = 0;
		{rst, off_en, m2_sel, fset} = {1'b1, 1'b0, 1'b0, 16'h0000};
		foreach (src[k]) src[k] = 16'h0000;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		for (int k = 0; k < 18; k++) rd(idx(k), dpc_pkg::RESP_OKAY, dpc_pkg::REG_RESET);
		$display("test reset values done");
		// Random legal value, range edge, then one past it refused and value kept
		for (int k = 0; k < 18; k++) begin
			v = 16'($unsigned($random(seed)) % (lim(idx(k)) + 1));
			wr(idx(k), v, dpc_pkg::RESP_OKAY);
			rd(idx(k), dpc_pkg::RESP_OKAY, v);
			wr(idx(k), lim(idx(k)), dpc_pkg::RESP_OKAY);
			wr(idx(k), lim(idx(k)) + 16'h0001, dpc_pkg::RESP_SLVERR);
			rd(idx(k), dpc_pkg::RESP_OKAY, lim(idx(k)));
		end
		wr(10'h089, 16'h0001, dpc_pkg::RESP_DECERR);
		rd(10'h089, dpc_pkg::RESP_DECERR, 16'h0000);
		$display("test ranges done");
		// Both motors differ so a wrong pick shows
		wr(10'h07C, 16'h0001, 2'h0);
		wr(10'h07D, 16'h0000, 2'h0);
		wr(10'h07E, 16'h04D2, 2'h0);
		wr(10'h07F, 16'h004D, 2'h0);
		wr(10'h080, 16'h0FA0, 2'h0);
		wr(10'h081, 16'h0005, 2'h0);
		wr(10'h083, 16'h0000, 2'h0);
		repeat (2) @(posedge clk_sys);
		check(34'({sw_m, acc_f, dec_f}), 34'({1'b1, 16'h04D2, 16'h0FA0}));
		check(34'({acc_s, dec_s}), 34'(2'b10));
		m2_sel <= 1'b1;
		wr(10'h082, 16'h0000, 2'h0);
		wr(10'h083, 16'h0001, 2'h0);
		repeat (8) @(posedge clk_sys);
		check(34'({sw_m, acc_f, dec_f}), 34'({1'b0, 16'h004D, 16'h0005}));
		check(34'({acc_s, dec_s}), 34'(2'b01));
		$display("test profiles done");
		// Current input scaling and start option
		wr(10'h084, 16'h012C, 2'h0);
		wr(10'h085, 16'h0F3C, 2'h0);
		wr(10'h086, 16'h0014, 2'h0);
		wr(10'h088, 16'h0000, 2'h0);
		repeat (2) @(posedge clk_sys);
		check(34'({cs_f, ce_f}), 34'({16'h012C, 16'h0F3C}));
		check(34'({cs_p, ce_p}), 34'({16'h0014, 16'h0064}));
		wr(10'h088, 16'h0001, 2'h0);
		repeat (2) @(posedge clk_sys);
		check(34'(cs_f), 34'(16'h0000));
		$display("test current input done");
		// Every source as A, its mirror as B, every operation
		foreach (src[k]) src[k] <= 16'($random(seed));
		for (int a = 0; a < 5; a++) begin
			for (int op = 0; op < 3; op++) begin
				wr(10'h0E3, 16'(a), 2'h0);
				wr(10'h0E4, 16'(4 - a), 2'h0);
				wr(10'h0E5, 16'(op), 2'h0);
				repeat (2) @(posedge clk_sys);
				check(34'(calc), 34'(cexp(src[a], src[4 - a], op)));
			end
		end
		$display("test calculate done");
		// Offset only while enabled, both directions, with floor at zero
		wr(10'h0E6, 16'h05DC, 2'h0);
		for (int k = 0; k < 8; k++) begin
			v = 16'($unsigned($random(seed)) % 4001);
			fset <= v;
			off_en <= k[0];
			wr(10'h0E7, {15'h0000, k[1]}, 2'h0);
			repeat (8) @(posedge clk_sys);
			e = !k[0] ? v : (!k[1] ? v + 16'h05DC : (v > 16'h05DC ? v - 16'h05DC : 16'h0000));
			check(34'(ofreq), 34'(e));
		end
		$display("test offset done");
		check(34'(wq.size() + rq.size()), 34'(0));
		stop_test();
	end

	// Whole run needs about 770 cycles
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_errors++;
		stop_test();
	end
endmodule : tb_drive_profile_calc_regs
`default_nettype wire
